// File: hdl/eiu_top.sv
// External interrupt unit: vector placement, sense control, flags and requests.
`default_nettype none

// Notes on behaviour
// - Vector select zero puts vectors at flash start; one at the fused boot start.
// - Interrupts blocked from change enable until after the instruction after the write.
// - The blocking never alters the global interrupt enable.
// - Change enable self-clears four cycles after setting, or on a vector select write.
// - Boot lock bits block interrupts while running from the other section.
// - Pull-up disable bit turns every port pull-up off.
// - Interrupts fire even when their pins are outputs.
// - Each pin-change group raises its own request on any enabled toggle.
// - Three mask registers choose which pins feed each group.
// - Pin changes are seen without the I/O clock and can wake the part.
// - Level mode requests for as long as the pin is low.
// - Edge sensing needs the I/O clock; low level works without it.
// - A low level that vanishes before wake-up gives no interrupt.
// - Sense register: pin one mode in bits 3:2, pin zero in 1:0.
// - Mode 00 senses low level, 01 any change.
// - Mode 10 senses falling edge, 11 rising edge.
// - Pins are sampled first; pulses over one clock are caught.
// - Enable bits 1 and 0 gate each pin with the global enable.
// - Edge trigger sets the pin flag; service or write-one clears; zero in level mode.
// - Pin-change trigger sets the group flag; service or write-one clears.
module eiu_top
  import eiu_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Pins
  input wire logic [NUM_EXT-1:0] i_ext_pin,
  input wire logic [PC_PINS-1:0] i_pc_pin,
  // Core status
  input wire logic i_global_enable,
  input wire logic i_io_clock_run,
  input wire logic i_instr_end,
  input wire logic i_exec_in_boot,
  input wire logic i_app_boot_lock,
  input wire logic i_boot_boot_lock,
  input wire logic [1:0] i_boot_size_fuses,
  input wire logic [NUM_EXT-1:0] i_ack_ext,
  input wire logic [NUM_PC_GRP-1:0] i_ack_pc,
  // Requests and controls
  output logic [NUM_EXT-1:0] o_irq_ext,
  output logic [NUM_PC_GRP-1:0] o_irq_pc,
  output logic o_irq_block,
  output logic o_vector_select,
  output logic [VEC_W-1:0] o_vector_base,
  output logic o_pullup_disable,
  output logic o_wake
);

  eiu_vc_state_t state;
  eiu_vc_state_t next_state;
  logic [2:0] vc_cnt;
  logic [2:0] next_vc_cnt;
  logic next_vsel;
  logic [3:0] sense;
  logic [NUM_EXT-1:0] ext_en;
  logic [NUM_PC_GRP-1:0] pc_en;
  logic [NUM_EXT-1:0] ext_flag;
  logic [NUM_PC_GRP-1:0] pc_flag;
  logic [NUM_PC_GRP-1:0][7:0] pc_mask;
  logic [NUM_PC_GRP-1:0] pc_hit;
  logic [NUM_EXT-1:0] ext_level;
  logic [7:0] mask_rd;

  eiu_det_if dif ();

  assign dif.ext_pin = i_ext_pin;
  assign dif.pc_pin = i_pc_pin;
  assign dif.sense = sense;
  assign dif.io_run = i_io_clock_run;

  eiu_detect u_detect (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .det(dif)
  );

  // Register port decoding.
  wire logic wr_cc = i_wr & reg_hit(i_addr, ADDR_CORE_CTRL);
  wire logic wr_sense = i_wr & reg_hit(i_addr, ADDR_EXT_SENSE);
  wire logic wr_ext_en = i_wr & reg_hit(i_addr, ADDR_EXT_ENABLE);
  wire logic wr_ext_flag = i_wr & reg_hit(i_addr, ADDR_EXT_FLAG);
  wire logic wr_pc_ctrl = i_wr & reg_hit(i_addr, ADDR_PC_CTRL);
  wire logic wr_pc_flag = i_wr & reg_hit(i_addr, ADDR_PC_FLAG);
  wire logic vce = (state == EIU_VC_OPEN);
  wire logic [NUM_EXT-1:0] clr_ext = (wr_ext_flag ? i_wdata[NUM_EXT-1:0] : '0) | i_ack_ext;
  wire logic [NUM_PC_GRP-1:0] clr_pc = (wr_pc_flag ? i_wdata[NUM_PC_GRP-1:0] : '0) | i_ack_pc;

  // Vector change sequence.
  always_comb
  begin
    next_state = state;
    next_vc_cnt = vc_cnt;
    next_vsel = o_vector_select;
    case (state)
      EIU_VC_IDLE:
      begin
        if (wr_cc && i_wdata[CC_VCE])
        begin
          next_state = EIU_VC_OPEN;
          next_vc_cnt = VCE_WINDOW_CYC;
        end
      end
      EIU_VC_OPEN:
      begin
        if (wr_cc && !i_wdata[CC_VCE])
        begin
          next_vsel = i_wdata[CC_VSEL];
          next_state = EIU_VC_TRAIL;
        end
        else if (wr_cc)
          next_vc_cnt = VCE_WINDOW_CYC;
        else if (vc_cnt == VC_CNT_LAST)
          next_state = EIU_VC_IDLE;
        else
          next_vc_cnt = vc_cnt - VC_CNT_LAST;
      end
      EIU_VC_TRAIL:
      begin
        if (wr_cc && i_wdata[CC_VCE])
        begin
          next_state = EIU_VC_OPEN;
          next_vc_cnt = VCE_WINDOW_CYC;
        end
        else if (i_instr_end)
          next_state = EIU_VC_IDLE;
      end
      default:
        next_state = EIU_VC_IDLE;
    endcase
  end

  // Automatic blocking only masks requests; the global enable is never written.
  wire logic lock_block = next_vsel ? (i_app_boot_lock & ~i_exec_in_boot) :
                                      (i_boot_boot_lock & i_exec_in_boot);
  wire logic next_block = (next_state != EIU_VC_IDLE) | lock_block;

  // Flags: a trigger in the clearing cycle wins over the clear.
  for (genvar i = 0; i < NUM_EXT; i++)
  begin : g_ext
    assign ext_level[i] = (sense[i*SENSE_W +: SENSE_W] == EIU_SENSE_LOW);
  end

  wire logic [NUM_EXT-1:0] next_ext_flag = ~ext_level & (dif.ext_edge | (ext_flag & ~clr_ext));
  wire logic [NUM_PC_GRP-1:0] next_pc_flag = pc_hit | (pc_flag & ~clr_pc);
  // A level request follows the sampled pin, so a level gone early raises nothing.
  wire logic [NUM_EXT-1:0] ext_req = (ext_level & dif.ext_low) | next_ext_flag;
  wire logic [NUM_EXT-1:0] next_irq_ext = ext_en & ext_req & {NUM_EXT{i_global_enable & ~next_block}};
  wire logic [NUM_PC_GRP-1:0] next_irq_pc = pc_en & next_pc_flag & {NUM_PC_GRP{i_global_enable & ~next_block}};
  // Wake needs neither the I/O clock nor the global enable.
  wire logic next_wake = |(ext_en & ext_level & dif.ext_low) | |(pc_en & pc_hit);
  wire logic [VEC_W-1:0] next_vbase = next_vsel ? boot_start(i_boot_size_fuses) : VEC_APP_START;

  // Pin-change groups with their mask registers.
  for (genvar g = 0; g < NUM_PC_GRP; g++)
  begin : g_pc
    logic [7:0] mask;
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
      if (!i_rst_b)
        mask <= RST_BYTE;
      else if (i_wr && reg_hit(i_addr, PC_MASK_ADDR[g]))
        mask <= i_wdata & PC_MASK_VALID[g];
    end
    assign pc_mask[g] = mask;
    assign pc_hit[g] = |(dif.pc_toggle[g*PC_GRP_W +: PC_GRP_W] & mask);
  end

  always_comb
  begin
    mask_rd = RST_BYTE;
    for (int g = 0; g < NUM_PC_GRP; g++)
      if (reg_hit(i_addr, PC_MASK_ADDR[g]))
        mask_rd = pc_mask[g];
  end

  wire logic [7:0] cc_rd = (8'(o_pullup_disable) << CC_PUD) | (8'(o_vector_select) << CC_VSEL) |
                           (8'(vce) << CC_VCE);
  wire logic [7:0] rd_val =
    reg_hit(i_addr, ADDR_CORE_CTRL) ? cc_rd :
    reg_hit(i_addr, ADDR_EXT_SENSE) ? {4'h0, sense} :
    reg_hit(i_addr, ADDR_EXT_ENABLE) ? 8'(ext_en) :
    reg_hit(i_addr, ADDR_EXT_FLAG) ? 8'(ext_flag) :
    reg_hit(i_addr, ADDR_PC_CTRL) ? 8'(pc_en) :
    reg_hit(i_addr, ADDR_PC_FLAG) ? 8'(pc_flag) : mask_rd;

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state <= EIU_VC_IDLE;
      vc_cnt <= 3'h0;
      o_vector_select <= 1'b0;
      o_pullup_disable <= 1'b0;
      sense <= RST_SENSE;
      ext_en <= '0;
      pc_en <= '0;
    end
    else
    begin
      state <= next_state;
      vc_cnt <= next_vc_cnt;
      o_vector_select <= next_vsel;
      if (wr_cc)
        o_pullup_disable <= i_wdata[CC_PUD];
      if (wr_sense)
        sense <= i_wdata[3:0];
      if (wr_ext_en)
        ext_en <= i_wdata[NUM_EXT-1:0];
      if (wr_pc_ctrl)
        pc_en <= i_wdata[NUM_PC_GRP-1:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ext_flag <= '0;
      pc_flag <= '0;
      o_irq_ext <= '0;
      o_irq_pc <= '0;
      o_irq_block <= 1'b0;
      o_wake <= 1'b0;
      o_vector_base <= VEC_APP_START;
      o_rdata <= RST_BYTE;
    end
    else
    begin
      ext_flag <= next_ext_flag;
      pc_flag <= next_pc_flag;
      o_irq_ext <= next_irq_ext;
      o_irq_pc <= next_irq_pc;
      o_irq_block <= next_block;
      o_wake <= next_wake;
      o_vector_base <= next_vbase;
      if (i_rd)
        o_rdata <= rd_val;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  chk_vce_self_clear: assert property (
    $rose(vce) ##0 (!wr_cc) [*4] |=> !vce)
    else $error("change enable outlived its four cycle window");

  chk_vce_holds_open: assert property (
    $rose(vce) ##0 (!wr_cc) [*3] |=> vce)
    else $error("change enable closed before four cycles");

  chk_vsel_needs_unlock: assert property (
    $changed(o_vector_select) |-> $past(vce) && $past(wr_cc))
    else $error("vector select changed without the unlock sequence");

  chk_block_during_open: assert property (
    vce |-> o_irq_block && o_irq_ext == '0 && o_irq_pc == '0)
    else $error("request passed while the vector change was open");

  chk_block_after_write: assert property (
    (vce && wr_cc && !i_wdata[CC_VCE]) |=> o_irq_block && !vce)
    else $error("blocking dropped right after the vector select write");

  chk_level_flag_clear: assert property (
    ext_level[0] |=> !ext_flag[0])
    else $error("pin zero flag set in level mode");

  chk_flag_set_wins: assert property (
    (dif.ext_edge[1] && !ext_level[1]) |=> ext_flag[1])
    else $error("pin one edge lost");

  chk_level_request: assert property (
    (ext_en[0] && i_global_enable && ext_level[0] && dif.ext_low[0] && !next_block) |=> o_irq_ext[0])
    else $error("low level on pin zero gave no request");

  chk_pc_flag_set: assert property (
    pc_hit[2] |=> pc_flag[2] && $past(i_pc_pin, 2) != $past(i_pc_pin, 3))
    else $error("group two toggle did not set its flag");

  chk_pullup_write: assert property (
    wr_cc |=> o_pullup_disable == $past(i_wdata[CC_PUD]))
    else $error("pull-up disable did not follow the write");

  chk_vector_base: assert property (
    !o_vector_select |-> o_vector_base == VEC_APP_START)
    else $error("vector base not at flash start");

  cov_vector_move: cover property ($rose(o_vector_select));
  cov_level_irq: cover property (ext_level[0] && o_irq_ext[0]);
  cov_pc_irq: cover property (o_irq_pc[0] ##1 i_ack_pc[0]);
  cov_vce_timeout: cover property ($fell(vce) && state == EIU_VC_IDLE);

endmodule
`default_nettype wire

// File: include/eiu_pkg.sv
// Package with register map, field layout and mode codes of the external interrupt unit.
`default_nettype none
package eiu_pkg;

  // Register offsets in data space.
  localparam logic [7:0] ADDR_PC_FLAG = 8'h3b;
  localparam logic [7:0] ADDR_EXT_FLAG = 8'h3c;
  localparam logic [7:0] ADDR_EXT_ENABLE = 8'h3d;
  localparam logic [7:0] ADDR_CORE_CTRL = 8'h55;
  localparam logic [7:0] ADDR_PC_CTRL = 8'h68;
  localparam logic [7:0] ADDR_EXT_SENSE = 8'h6a;

  localparam int NUM_EXT = 2;
  localparam int NUM_PC_GRP = 3;
  localparam int PC_GRP_W = 8;
  localparam int PC_PINS = NUM_PC_GRP * PC_GRP_W;
  localparam int SENSE_W = 2;

  localparam logic [7:0] PC_MASK_ADDR [NUM_PC_GRP] = '{8'h6b, 8'h6c, 8'h6d};
  localparam logic [7:0] PC_MASK_VALID [NUM_PC_GRP] = '{8'hff, 8'h7f, 8'hff};

  // Field positions in the core control register.
  localparam int CC_PUD = 4;
  localparam int CC_VSEL = 1;
  localparam int CC_VCE = 0;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_SENSE = 4'h0;

  // Change enable stays open for this many cycles.
  localparam logic [2:0] VCE_WINDOW_CYC = 3'h4;
  localparam logic [2:0] VC_CNT_LAST = 3'h1;

  // Vector table word addresses; boot starts are plain defaults per fuse setting.
  localparam int VEC_W = 13;
  localparam logic [VEC_W-1:0] VEC_APP_START = 13'h0000;
  localparam logic [VEC_W-1:0] BOOT_START_SZ0 = 13'h1000;
  localparam logic [VEC_W-1:0] BOOT_START_SZ1 = 13'h1400;
  localparam logic [VEC_W-1:0] BOOT_START_SZ2 = 13'h1800;
  localparam logic [VEC_W-1:0] BOOT_START_SZ3 = 13'h1c00;

  typedef enum logic [1:0] {
    EIU_SENSE_LOW = 2'h0,
    EIU_SENSE_ANY = 2'h1,
    EIU_SENSE_FALL = 2'h2,
    EIU_SENSE_RISE = 2'h3
  } eiu_sense_t;

  typedef enum logic [1:0] {
    EIU_VC_IDLE,
    EIU_VC_OPEN,
    EIU_VC_TRAIL
  } eiu_vc_state_t;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  function automatic logic [VEC_W-1:0] boot_start(input logic [1:0] fuses);
    logic [VEC_W-1:0] base;
    case (fuses)
      2'h0: base = BOOT_START_SZ0;
      2'h1: base = BOOT_START_SZ1;
      2'h2: base = BOOT_START_SZ2;
      default: base = BOOT_START_SZ3;
    endcase
    return base;
  endfunction

endpackage
`default_nettype wire

// File: include/eiu_det_if.sv
// Interface between the control block and the pin detector.
`default_nettype none
interface eiu_det_if;
  import eiu_pkg::*;
  logic [NUM_EXT-1:0] ext_pin;
  logic [PC_PINS-1:0] pc_pin;
  logic [NUM_EXT*SENSE_W-1:0] sense;
  logic io_run;
  logic [NUM_EXT-1:0] ext_edge;
  logic [NUM_EXT-1:0] ext_low;
  logic [PC_PINS-1:0] pc_toggle;

  modport det (input ext_pin, input pc_pin, input sense, input io_run,
               output ext_edge, output ext_low, output pc_toggle);
  modport ctl (output ext_pin, output pc_pin, output sense, output io_run,
               input ext_edge, input ext_low, input pc_toggle);
endinterface
`default_nettype wire

// File: hdl/eiu_detect.sv
// Pin sampler with edge, level and pin-change detection.
`default_nettype none
module eiu_detect
  import eiu_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Detector side
  eiu_det_if.det det
);

  logic [NUM_EXT-1:0] ext_smp;
  logic [NUM_EXT-1:0] ext_prev;
  logic [PC_PINS-1:0] pc_smp;
  logic [PC_PINS-1:0] pc_prev;
  logic smp_ok;
  logic prev_ok;

  // Pins are sampled before any comparison, whatever their direction.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ext_smp <= '0;
      ext_prev <= '0;
      pc_smp <= '0;
      pc_prev <= '0;
      smp_ok <= 1'b0;
      prev_ok <= 1'b0;
    end
    else
    begin
      ext_smp <= det.ext_pin;
      ext_prev <= ext_smp;
      pc_smp <= det.pc_pin;
      pc_prev <= pc_smp;
      smp_ok <= 1'b1;
      prev_ok <= smp_ok;
    end
  end

  for (genvar i = 0; i < NUM_EXT; i++)
  begin : g_ext
    wire eiu_sense_t mode = eiu_sense_t'(det.sense[i*SENSE_W +: SENSE_W]);
    wire logic rise = ext_smp[i] & ~ext_prev[i];
    wire logic fall = ~ext_smp[i] & ext_prev[i];
    wire logic hit = (mode == EIU_SENSE_ANY) ? (rise | fall) :
                     (mode == EIU_SENSE_FALL) ? fall :
                     (mode == EIU_SENSE_RISE) & rise;
    // Edges are only seen while the I/O clock runs.
    assign det.ext_edge[i] = det.io_run & prev_ok & hit;
    assign det.ext_low[i] = smp_ok & ~ext_smp[i];
  end

  assign det.pc_toggle = prev_ok ? (pc_smp ^ pc_prev) : '0;

  chk_edge_needs_clock: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !det.io_run |-> det.ext_edge == '0)
    else $error("edge reported while the I/O clock is stopped");

  chk_rise_detected: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (det.io_run && prev_ok && det.sense[SENSE_W-1:0] == EIU_SENSE_RISE && ext_smp[0] && !ext_prev[0])
    |-> det.ext_edge[0])
    else $error("rising edge on pin zero missed");

endmodule
`default_nettype wire

// File: tb/eiu_pin_source.sv
// Behavioural model of the pin sources that face the external interrupt unit.
`default_nettype none
module eiu_pin_source
  import eiu_pkg::*;
(
  // Clock
  input wire logic i_clock,
  // Pins
  output logic [NUM_EXT-1:0] o_ext_pin,
  output logic [PC_PINS-1:0] o_pc_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    o_ext_pin = '1;
    o_pc_pin = '0;
  end

  // The level is held for several clocks, so it outlasts any instruction and the pin sampler.
  task automatic drive_ext(input int n, input logic lvl, input int hold);
    @(negedge i_clock);
    o_ext_pin[n] = lvl;
    repeat (hold) @(negedge i_clock);
  endtask

  task automatic toggle_pc(input int n, input int hold);
    @(negedge i_clock);
    o_pc_pin[n] = ~o_pc_pin[n];
    repeat (hold) @(negedge i_clock);
  endtask
endmodule
`default_nettype wire

// File: tb/eiu_top_tb_top.sv
// Self-checking testbench of the external interrupt unit.
`default_nettype none
module eiu_top_tb_top
  import eiu_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] RST_LIST [7] = '{ADDR_CORE_CTRL, ADDR_EXT_ENABLE, ADDR_EXT_FLAG, ADDR_PC_FLAG,
                                          ADDR_PC_CTRL, ADDR_EXT_SENSE, 8'h00};
  localparam int PC_IDX [6] = '{0, 1, 15, 14, 23, 16};
  localparam logic [7:0] PC_EXP [6] = '{8'h01, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00};

  logic clk;
  logic rst_b;
  logic [7:0] addr;
  logic [7:0] wdat;
  logic wr_s;
  logic rd_s;
  logic [7:0] rdata;
  logic [NUM_EXT-1:0] ext_pin;
  logic [PC_PINS-1:0] pc_pin;
  logic instr_end;
  logic in_boot;
  logic app_lock;
  logic boot_lock;
  logic glob_en;
  logic io_run;
  logic [1:0] fuses;
  logic [NUM_EXT-1:0] ack_ext;
  logic [NUM_PC_GRP-1:0] ack_pc;
  logic [NUM_EXT-1:0] irq_ext;
  logic [NUM_PC_GRP-1:0] irq_pc;
  logic irq_block;
  logic vsel;
  logic [VEC_W-1:0] vbase;
  logic pullup_disable;
  logic wake;
  int err_total;
  int samples_checked;
  int cycles;

  eiu_top u_eiu_top (
    .i_clock(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdat), .i_wr(wr_s), .i_rd(rd_s),
    .o_rdata(rdata), .i_ext_pin(ext_pin), .i_pc_pin(pc_pin), .i_global_enable(glob_en),
    .i_io_clock_run(io_run), .i_instr_end(instr_end), .i_exec_in_boot(in_boot),
    .i_app_boot_lock(app_lock), .i_boot_boot_lock(boot_lock), .i_boot_size_fuses(fuses),
    .i_ack_ext(ack_ext), .i_ack_pc(ack_pc), .o_irq_ext(irq_ext), .o_irq_pc(irq_pc),
    .o_irq_block(irq_block), .o_vector_select(vsel), .o_vector_base(vbase),
    .o_pullup_disable(pullup_disable), .o_wake(wake)
  );

  eiu_pin_source u_eiu_pin_source (.i_clock(clk), .o_ext_pin(ext_pin), .o_pc_pin(pc_pin));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // The run is about 360 cycles; the ceiling leaves wide margin.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdat = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    chk($sformatf("register %h", a), 16'(exp), 16'(rdata));
  endtask

  task automatic pulse_end();
    @(negedge clk);
    instr_end = 1'b1;
    @(negedge clk);
    instr_end = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  initial
  begin
    rst_b = 1'b0;
    addr = 8'h00;
    wdat = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    instr_end = 1'b0;
    in_boot = 1'b0;
    app_lock = 1'b0;
    ack_pc = '0;
    boot_lock = 1'b0;
    glob_en = 1'b1;
    io_run = 1'b1;
    fuses = 2'h3;
    ack_ext = '0;
    err_total = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    foreach (RST_LIST[i])
      rdchk(RST_LIST[i], 8'h00);
    wr(ADDR_EXT_ENABLE, 8'hff);
    rdchk(ADDR_EXT_ENABLE, 8'h03);
    wr(PC_MASK_ADDR[1], 8'hff);
    rdchk(PC_MASK_ADDR[1], 8'h7f);
    wr(8'h00, 8'hff);
    rdchk(8'h00, 8'h00);
    // A vector select write without the unlock must be ignored.
    wr(ADDR_CORE_CTRL, 8'h12);
    chk("pullup disable", 16'h1, 16'(pullup_disable));
    rdchk(ADDR_CORE_CTRL, 8'h10);
    wr(ADDR_CORE_CTRL, 8'h11);
    chk("block on unlock", 16'h1, 16'(irq_block));
    wr(ADDR_CORE_CTRL, 8'h12);
    chk("vector select", 16'h1, 16'(vsel));
    chk("vector base", 16'(BOOT_START_SZ3), 16'(vbase));
    chk("block after move", 16'h1, 16'(irq_block));
    rdchk(ADDR_CORE_CTRL, 8'h12);
    pulse_end();
    chk("block released", 16'h0, 16'(irq_block));
    wr(ADDR_CORE_CTRL, 8'h13);
    repeat (5) @(negedge clk);
    chk("block timeout", 16'h0, 16'(irq_block));
    rdchk(ADDR_CORE_CTRL, 8'h12);
    app_lock = 1'b1;
    repeat (2) @(negedge clk);
    chk("lock from app", 16'h1, 16'(irq_block));
    in_boot = 1'b1;
    repeat (2) @(negedge clk);
    chk("lock from boot", 16'h0, 16'(irq_block));
    fuses = 2'h0;
    repeat (2) @(negedge clk);
    chk("vector base fuse", 16'(BOOT_START_SZ0), 16'(vbase));
    app_lock = 1'b0;
    in_boot = 1'b0;
    wr(ADDR_CORE_CTRL, 8'h01);
    wr(ADDR_CORE_CTRL, 8'h00);
    chk("vector base app", 16'(VEC_APP_START), 16'(vbase));
    chk("pullup enable", 16'h0, 16'(pullup_disable));
    pulse_end();
    boot_lock = 1'b1;
    in_boot = 1'b1;
    repeat (2) @(negedge clk);
    chk("boot lock from boot", 16'h1, 16'(irq_block));
    in_boot = 1'b0;
    repeat (2) @(negedge clk);
    chk("boot lock from app", 16'h0, 16'(irq_block));
    boot_lock = 1'b0;
    for (int n = 0; n < NUM_EXT; n++)
      for (int m = 0; m < 4; m++)
      begin
        wr(ADDR_EXT_SENSE, 8'(m << (2 * n)));
        wr(ADDR_EXT_ENABLE, 8'(1 << n));
        wr(ADDR_EXT_FLAG, 8'h03);
        u_eiu_pin_source.drive_ext(n, 1'b0, 4);
        chk("ext irq low", (m != 3) ? 16'(1 << n) : 16'h0, 16'(irq_ext));
        rdchk(ADDR_EXT_FLAG, (m == 1 || m == 2) ? 8'(1 << n) : 8'h00);
        u_eiu_pin_source.drive_ext(n, 1'b1, 5);
        chk("ext irq high", (m != 0) ? 16'(1 << n) : 16'h0, 16'(irq_ext));
        rdchk(ADDR_EXT_FLAG, (m != 0) ? 8'(1 << n) : 8'h00);
      end
    wr(ADDR_EXT_FLAG, 8'h03);
    rdchk(ADDR_EXT_FLAG, 8'h00);
    wr(PC_MASK_ADDR[0], 8'h01);
    wr(PC_MASK_ADDR[2], 8'h80);
    wr(ADDR_PC_CTRL, 8'h07);
    foreach (PC_IDX[i])
    begin
      wr(ADDR_PC_FLAG, 8'h07);
      u_eiu_pin_source.toggle_pc(PC_IDX[i], 4);
      chk("pin change irq", 16'(PC_EXP[i]), 16'(irq_pc));
      rdchk(ADDR_PC_FLAG, PC_EXP[i]);
    end
    wr(ADDR_PC_FLAG, 8'h07);
    u_eiu_pin_source.toggle_pc(0, 4);
    @(negedge clk);
    ack_pc = 3'b001;
    @(negedge clk);
    ack_pc = 3'b000;
    rdchk(ADDR_PC_FLAG, 8'h00);
    wr(ADDR_PC_CTRL, 8'h00);
    u_eiu_pin_source.toggle_pc(0, 4);
    chk("pin change gated", 16'h0, 16'(irq_pc));
    rdchk(ADDR_PC_FLAG, 8'h01);
    // Without the I/O clock an edge is missed, while a low level still requests and wakes.
    wr(ADDR_EXT_SENSE, 8'h02);
    wr(ADDR_EXT_ENABLE, 8'h01);
    io_run = 1'b0;
    u_eiu_pin_source.drive_ext(0, 1'b0, 4);
    rdchk(ADDR_EXT_FLAG, 8'h00);
    chk("wake on edge", 16'h0, 16'(wake));
    wr(ADDR_EXT_SENSE, 8'h00);
    repeat (2) @(negedge clk);
    chk("wake on low", 16'h1, 16'(wake));
    chk("level without clock", 16'h1, 16'(irq_ext));
    glob_en = 1'b0;
    repeat (2) @(negedge clk);
    chk("global enable gate", 16'h0, 16'(irq_ext));
    chk("wake without enable", 16'h1, 16'(wake));
    glob_en = 1'b1;
    io_run = 1'b1;
    u_eiu_pin_source.drive_ext(0, 1'b1, 4);
    chk("wake released", 16'h0, 16'(wake));
    // Servicing the request clears the pin flag.
    wr(ADDR_EXT_SENSE, 8'h01);
    u_eiu_pin_source.drive_ext(0, 1'b0, 4);
    chk("ext irq before service", 16'h1, 16'(irq_ext));
    ack_ext = 2'b01;
    @(negedge clk);
    ack_ext = 2'b00;
    rdchk(ADDR_EXT_FLAG, 8'h00);
    chk("ext irq serviced", 16'h0, 16'(irq_ext));
    tally_and_finish();
  end
endmodule
`default_nettype wire
